/* File: src/opc_defines.vh */
`ifndef OPC_DEFINES_VH
`define OPC_DEFINES_VH
// Register indices; the bus byte address is four times the index.
`define OPC_ADDR_PAT_LO 8'h51
`define OPC_ADDR_PAT_HI 8'h52
`define OPC_ADDR_CORR 8'h53
`define OPC_ADDR_TPAT 8'h62
`define OPC_ADDR_PED 8'h63
`define OPC_ADDR_CTRL 8'h70
`define OPC_ADDR_STAT 8'h74
// Field positions.
`define OPC_PED_MSB 5
`define OPC_PED_LSB 3
`define OPC_PLO_MSB 7
`define OPC_PLO_LSB 3
`define OPC_PHI_MSB 5
`define OPC_PHI_LSB 0
`define OPC_CORR_EN_BIT 6
`define OPC_TPAT_CUSTOM 3'h5
// Reset values.
`define OPC_RST_REG 8'h00
`define OPC_MIDCODE 11'h400
// Output clock half period in sample clocks (the period is twice this).
`define OPC_HALF_CYC 2'h2
`endif

/* File: src/opc_skid.v */
`timescale 1ns/1ps
`default_nettype none
// Two-entry buffer for sample words; drains only when the serializer is ready.
module opc_skid (
  input wire aclk,
  input wire aresetn,
  input wire [23:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [23:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  reg [23:0] mem_r [0:1];
  reg wp_r;
  reg rp_r;
  reg [1:0] cnt_r;
  wire push = in_valid && (cnt_r != 2'h2);
  wire pop = out_ready && (cnt_r != 2'h0);
  assign in_ready = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign out_data = mem_r[rp_r];
  // Pointers and occupancy; a full buffer refuses new words rather than overwrite.
  always @(posedge aclk) begin
    if (!aresetn) begin
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      if (push) begin
        mem_r[wp_r] <= in_data;
        wp_r <= ~wp_r;
      end
      if (pop)
        rp_r <= ~rp_r;
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule // opc_skid
`default_nettype wire

/* File: src/opc_top.v */
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "opc_defines.vh"
module opc_top (
  input wire aclk,
  input wire aresetn,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [10:0] adc_a_raw,
  input wire [10:0] adc_b_raw,
  input wire sample_valid,
  input wire common_ctrl,
  output reg output_clock_true,
  output reg [5:0] lvds_a_data,
  output reg [5:0] lvds_b_data
);
  reg [7:0] pat_lo_r;
  reg [7:0] pat_hi_r;
  reg [7:0] corr_r;
  reg [7:0] tpat_r;
  reg [7:0] converged_target_trim_a_r;
  reg [7:0] ctrl_r;
  reg [10:0] offset_a_r;
  reg [10:0] offset_b_r;
  reg [10:0] out_a_r;
  reg [10:0] out_b_r;
  reg aw_got_r;
  reg w_got_r;
  reg [7:0] aw_addr_r;
  reg [31:0] w_data_r;
  reg [3:0] w_strb_r;
  reg [1:0] ph_r;
  reg [23:0] cur_r;
  reg cur_valid_r;
  wire [5:0] even_a;
  wire [5:0] odd_a;
  wire [5:0] even_b;
  wire [5:0] odd_b;
  wire [11:0] pat_word;
  wire signed [11:0] trim;
  wire [10:0] target;
  wire [10:0] pre_a;
  wire [10:0] pre_b;
  wire [23:0] fifo_out;
  wire fifo_valid;
  wire fifo_in_ready;
  wire load_cur;
  wire custom_on;
  wire corr_on;

  // Custom pattern word: dummy bit zero, then five low then six high pattern bits.
  assign pat_word = {pat_hi_r[`OPC_PHI_MSB:`OPC_PHI_LSB],
    pat_lo_r[`OPC_PLO_MSB:`OPC_PLO_LSB], 1'b0};
  assign custom_on = (tpat_r[2:0] == `OPC_TPAT_CUSTOM);
  assign corr_on = corr_r[`OPC_CORR_EN_BIT];
  // Sign-extend the trim field and add it to mid-code.
  assign trim = {{9{converged_target_trim_a_r[`OPC_PED_MSB]}},
    converged_target_trim_a_r[`OPC_PED_MSB:`OPC_PED_LSB]};
  assign target = `OPC_MIDCODE + trim[10:0];
  // Corrected codes; the offset estimate is frozen while correction is off.
  assign pre_a = corr_on ? (adc_a_raw - offset_a_r + target) : adc_a_raw;
  assign pre_b = (corr_on && common_ctrl) ? (adc_b_raw - offset_b_r + target)
    : adc_b_raw;

  // Offset loop: first-order tracker nudging the A estimate, and the B estimate while common_ctrl is set, by one LSB per sample.
  always @(posedge aclk) begin
    if (!aresetn) begin
      offset_a_r <= `OPC_MIDCODE;
      offset_b_r <= `OPC_MIDCODE;
    end else if (corr_on && sample_valid) begin
      if (pre_a > target)
        offset_a_r <= offset_a_r + 11'h001;
      else if (pre_a < target)
        offset_a_r <= offset_a_r - 11'h001;
      if (common_ctrl && pre_b > target)
        offset_b_r <= offset_b_r + 11'h001;
      else if (common_ctrl && pre_b < target)
        offset_b_r <= offset_b_r - 11'h001;
    end
  end

  // Output word selection per channel.
  always @(posedge aclk) begin
    if (!aresetn) begin
      out_a_r <= 11'h000;
      out_b_r <= 11'h000;
    end else begin
      out_a_r <= custom_on ? pat_word[11:1] : pre_a;
      out_b_r <= custom_on ? pat_word[11:1] : pre_b;
    end
  end

  opc_skid opc_skid_inst (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_data({out_b_r, 1'b0, out_a_r, 1'b0}),
    .in_valid(sample_valid),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out),
    .out_valid(fifo_valid),
    .out_ready(load_cur)
  );

  // A new word is taken at the start of each output clock period.
  assign load_cur = (ph_r == 2'h3) || !cur_valid_r;

  // Split the current word into its even and odd bit lanes, one pass per bit pair.
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_lane
      assign even_a[gi] = cur_r[2 * gi];
      assign odd_a[gi] = cur_r[2 * gi + 1];
      assign even_b[gi] = cur_r[12 + 2 * gi];
      assign odd_b[gi] = cur_r[13 + 2 * gi];
    end
  endgenerate

  // Serializer: ph 0/1 clock high with even bits, ph 2/3 low with odd bits.
  // Each half stands two aclk cycles so a slow capture clock sees both bits.
  always @(posedge aclk) begin
    if (!aresetn) begin
      ph_r <= 2'h0;
      cur_r <= 24'h000000;
      cur_valid_r <= 1'b0;
      output_clock_true <= 1'b0;
      lvds_a_data <= 6'h00;
      lvds_b_data <= 6'h00;
    end else begin
      ph_r <= ph_r + 2'h1;
      // An empty buffer keeps the old word, so no unwritten entry reaches the pins.
      if (load_cur) begin
        if (fifo_valid)
          cur_r <= fifo_out;
        cur_valid_r <= fifo_valid;
      end
      output_clock_true <= (ph_r[1] == 1'b0) ? 1'b1 : 1'b0;
      if (ph_r[1] == 1'b0) begin
        lvds_a_data <= even_a;
        lvds_b_data <= even_b;
      end else begin
        lvds_a_data <= odd_a;
        lvds_b_data <= odd_b;
      end
    end
  end

  // AXI4-Lite write: address and data taken in either order, response after both.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      pat_lo_r <= `OPC_RST_REG;
      pat_hi_r <= `OPC_RST_REG;
      corr_r <= `OPC_RST_REG;
      tpat_r <= `OPC_RST_REG;
      converged_target_trim_a_r <= `OPC_RST_REG;
      ctrl_r <= `OPC_RST_REG;
    end else begin
      s_axi_awready <= s_axi_awvalid && !aw_got_r && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= s_axi_wvalid && !w_got_r && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr[9:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (aw_got_r && w_got_r && !s_axi_bvalid) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'h0;
        if (!w_strb_r[0])
          s_axi_bresp <= 2'h0;
        else if (aw_addr_r == `OPC_ADDR_PAT_LO)
          pat_lo_r <= {w_data_r[7:3], 3'h0};
        else if (aw_addr_r == `OPC_ADDR_PAT_HI)
          pat_hi_r <= {2'h0, w_data_r[5:0]};
        else if (aw_addr_r == `OPC_ADDR_CORR)
          corr_r <= {1'b0, w_data_r[6], 6'h00};
        else if (aw_addr_r == `OPC_ADDR_TPAT)
          tpat_r <= {5'h00, w_data_r[2:0]};
        else if (aw_addr_r == `OPC_ADDR_PED)
          converged_target_trim_a_r <= {2'h0, w_data_r[5:3], 3'h0};
        else if (aw_addr_r == `OPC_ADDR_CTRL)
          ctrl_r <= w_data_r[7:0];
        else
          s_axi_bresp <= 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI4-Lite read; the status word shows the live loop target and the channel A output code.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        // Word addressed: bits 9:2 carry the register index.
        if (s_axi_araddr[9:2] == `OPC_ADDR_PAT_LO)
          s_axi_rdata <= {24'h000000, pat_lo_r};
        else if (s_axi_araddr[9:2] == `OPC_ADDR_PAT_HI)
          s_axi_rdata <= {24'h000000, pat_hi_r};
        else if (s_axi_araddr[9:2] == `OPC_ADDR_CORR)
          s_axi_rdata <= {24'h000000, corr_r};
        else if (s_axi_araddr[9:2] == `OPC_ADDR_TPAT)
          s_axi_rdata <= {24'h000000, tpat_r};
        else if (s_axi_araddr[9:2] == `OPC_ADDR_PED)
          s_axi_rdata <= {24'h000000, converged_target_trim_a_r};
        else if (s_axi_araddr[9:2] == `OPC_ADDR_CTRL)
          s_axi_rdata <= {24'h000000, ctrl_r};
        else if (s_axi_araddr[9:2] == `OPC_ADDR_STAT)
          s_axi_rdata <= {5'h00, target, 5'h00, out_a_r};
        else begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= 2'h2;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // opc_top
`default_nettype wire

/* File: verification/opc_top_sva.sv */
`timescale 1ns/1ps
`default_nettype none
// Watches the register bus handshakes and the double-rate output words.
module opc_top_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic output_clock_true,
  input wire logic [5:0] lvds_a_data,
  input wire logic [5:0] lvds_b_data
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // The output clock spends exactly two sample clocks in each phase.
  a_clk_high_two: assert property ($rose(output_clock_true) |=>
    output_clock_true ##1 !output_clock_true) else $error("output clock high phase wrong");
  a_clk_low_two: assert property ($fell(output_clock_true) |=>
    !output_clock_true ##1 output_clock_true) else $error("output clock low phase wrong");
  a_dummy_bit_low: assert property (output_clock_true |->
    !lvds_a_data[0] && !lvds_b_data[0]) else $error("dummy bit not zero");
  a_bvalid_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid)
    else $error("write answer late");
  a_unmapped_err: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr[9:2] == 8'h00 |=> s_axi_rresp == 2'h2) else $error("unmapped read not refused");
  a_no_new_read: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
endmodule // opc_top_sva
bind opc_top opc_top_sva opc_top_sva_inst (.*);
`default_nettype wire

/* File: verification/opc_capture.sv */
`timescale 1ns/1ps
`default_nettype none
// Capture logic on the far side: rebuilds each 12-bit word and keeps the eleven data bits.
module opc_capture (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic output_clock_true,
  input wire logic [5:0] lvds_a_data,
  input wire logic [5:0] lvds_b_data,
  output var logic [10:0] word_a,
  output var logic [10:0] word_b
);
  logic [5:0] even_a_r;
  logic [5:0] even_b_r;
  // Even bits arrive in the high phase and odd bits in the low phase.
  function automatic logic [10:0] join_bits(input logic [5:0] e, input logic [5:0] o);
    logic [11:0] w;
    for (int i = 0; i < 6; i++) begin
      w[2*i] = e[i];
      w[2*i+1] = o[i];
    end
    return w[11:1];
  endfunction
  // Holding the even half lets the word be assembled once the odd half shows.
  always @(posedge aclk) begin
    if (!aresetn) begin
      even_a_r <= 6'h00;
      even_b_r <= 6'h00;
      word_a <= 11'h000;
      word_b <= 11'h000;
    end else if (output_clock_true) begin
      even_a_r <= lvds_a_data;
      even_b_r <= lvds_b_data;
    end else begin
      word_a <= join_bits(even_a_r, lvds_a_data);
      word_b <= join_bits(even_b_r, lvds_b_data);
    end
  end
endmodule // opc_capture
`default_nettype wire

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, d;
  logic [10:0] adc_a_raw = 11'h40A, adc_b_raw = 11'h3F0, cap_a, cap_b;
  logic sample_valid = 1'b1, common_ctrl = 1'b1, output_clock_true;
  logic [5:0] lvds_a_data, lvds_b_data;
  logic [1:0] r;
  int fails = 0, compares = 0, cyc = 0, e, lag = 0;
  opc_top opc_top_inst (.*);
  opc_capture opc_capture_inst (.aclk(aclk), .aresetn(aresetn),
    .output_clock_true(output_clock_true), .lvds_a_data(lvds_a_data),
    .lvds_b_data(lvds_b_data), .word_a(cap_a), .word_b(cap_b));
  // Free-running 125 MHz sample clock.
  initial begin
    forever #4 aclk = ~aclk;
  end
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] s);
    compares++;
    if (s !== x) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, s);
    end
  endtask
  task print_verdict;
    if (fails == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Address and data go out together; each is dropped once its ready is seen.
  // The index goes out as a word address; lag delays the response ready on purpose.
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    s_axi_awaddr <= {22'h0, a, 2'h0};
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= (lag == 0);
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) n++;
      if (n >= lag && !s_axi_bready) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid && s_axi_bready));
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    s_axi_araddr <= {22'h0, a, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= (lag == 0);
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) n++;
      if (n >= lag && !s_axi_rready) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid && s_axi_rready));
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  // A hang counts as a mismatch; the full run needs well under 5000 cycles.
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 8000) begin
      fails++;
      print_verdict;
    end
  end
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    wr(8'h51, 32'hA1);
    wr(8'h52, 32'h2A);
    wr(8'h62, 32'h05);
    repeat (40) @(posedge aclk);
    chk("pattern_a", 32'h554, {21'h0, cap_a});
    chk("pattern_b", 32'h554, {21'h0, cap_b});
    wr(8'h62, 32'h00);
    lag = 2;
    wr(8'h63, 32'h18);
    rd(8'h63);
    lag = 0;
    chk("trim_reg", 32'h18, d);
    repeat (40) @(posedge aclk);
    chk("raw_a", {21'h0, adc_a_raw}, {21'h0, cap_a});
    rd(8'h74);
    chk("stat_out_a", {21'h0, adc_a_raw}, {21'h0, d[10:0]});
    wr(8'h53, 32'h40);
    for (int i = 0; i < 8; i++) begin
      wr(8'h63, i << 3);
      repeat (100) @(posedge aclk);
      e = 1024 + (i < 4 ? i : i - 8);
      rd(8'h74);
      chk("target", e, {21'h0, d[26:16]});
      chk("conv_a", e, {21'h0, cap_a});
      chk("conv_b", e, {21'h0, cap_b});
    end
    common_ctrl <= 1'b0;
    repeat (40) @(posedge aclk);
    chk("indep_b", {21'h0, adc_b_raw}, {21'h0, cap_b});
    rd(8'h00);
    chk("rd_err", 32'h2, {30'h0, r});
    wr(8'h00, 32'h00);
    chk("wr_err", 32'h2, {30'h0, r});
    print_verdict;
  end
endmodule // tb_top
`default_nettype wire
